// ---- rtl/epc_pkg.sv ----
// Constants and types for the exception priority controller
package epc_pkg;
    localparam int NUM_POS = 48;
    localparam int NUM_IRQ = 32;
    localparam int NUM_SYS = 7;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_EN_SET    = 8'h04;
    localparam logic [7:0] ADDR_EN_CLR    = 8'h08;
    localparam logic [7:0] ADDR_PEND      = 8'h0C;
    localparam logic [7:0] ADDR_SYS_PRI   = 8'h10;
    localparam logic [7:0] ADDR_INT_PRI   = 8'h20;
    localparam logic [7:0] ADDR_INT_LAST  = 8'h3C;
    localparam logic [7:0] ADDR_LINE_PEND = 8'h40;
    // Control register fields
    localparam int CTRL_GRP_LSB = 0;
    localparam int CTRL_MEM_EN  = 8;
    localparam int CTRL_BUS_EN  = 9;
    localparam int CTRL_USE_EN  = 10;
    localparam int CTRL_DBG_EN  = 11;
    // Pend/state register fields
    localparam int PEND_ACT_LSB = 0;
    localparam int PEND_VEC_LSB = 12;
    localparam int PEND_REQ     = 22;
    localparam int PEND_PSV_CLR = 27;
    localparam int PEND_PSV_SET = 28;
    localparam int PEND_NMI_SET = 31;
    // Priority fields: sys word 4 bits per handler, irq word 8 bits per line
    localparam int SYS_FLD_W = 4;
    localparam int INT_FLD_W = 8;
    // Exception positions
    localparam logic [5:0] POS_RESET = 6'h01;
    localparam logic [5:0] POS_NMI   = 6'h02;
    localparam logic [5:0] POS_HARD  = 6'h03;
    localparam logic [5:0] POS_MEM   = 6'h04;
    localparam logic [5:0] POS_BUS   = 6'h05;
    localparam logic [5:0] POS_USAGE = 6'h06;
    localparam logic [5:0] POS_SVC   = 6'h0B;
    localparam logic [5:0] POS_DEBUG = 6'h0C;
    localparam logic [5:0] POS_PSV   = 6'h0E;
    localparam logic [5:0] POS_TICK  = 6'h0F;
    localparam logic [5:0] POS_IRQ0  = 6'h10;
    // Settable handlers, index 0 last
    localparam logic [NUM_SYS-1:0][5:0] SYS_POS =
        {POS_TICK, POS_PSV, POS_DEBUG, POS_SVC, POS_USAGE, POS_BUS, POS_MEM};
    // Internal rank: lower is more urgent
    localparam logic [4:0] LVL_RESET    = 5'h00;
    localparam logic [4:0] LVL_NMI      = 5'h01;
    localparam logic [4:0] LVL_HARD     = 5'h02;
    localparam logic [4:0] LVL_SET_BASE = 5'h03;
    localparam logic [4:0] LVL_BASE     = 5'h1F;
    // Reset values and the implemented-line mask
    localparam logic [2:0]  PRI_RESET  = 3'h0;
    localparam logic [1:0]  GRP_RESET  = 2'h0;
    localparam logic [31:0] IRQ_IMPL   = 32'h33FF_CFFF;
    typedef struct packed {
        logic mem;
        logic busPrecise;
        logic busImprecise;
        logic usage;
        logic svc;
        logic debug;
        logic tick;
    } epc_event_s;
    typedef struct packed {
        logic stackPush;
        logic vectorFetch;
        logic stackPop;
        logic tailChain;
    } epc_seq_s;
    typedef enum logic [2:0] {
        S_RUN   = 3'b001,
        S_ENTRY = 3'b010,
        S_EXIT  = 3'b100
    } epc_state_e;
endpackage

// ---- rtl/epc_exception_ctrl.sv ----
// Exception prioritisation and entry/exit sequencing with APB registers
// Behaviour
// - Eight settable levels, seven handlers, 26 lines
// - Level zero ranks below reset, NMI, hardfault
// - All settable priorities reset to zero
// - Equal level: lower position wins
// - Push state on entry, pop on exit
// - Vector fetch alongside state push
// - Pending at exit chains without pop/push
// - Handlers run in handler mode
// - Group/sub split; only group preempts
// - Reset highest, drops to base after start
// - NMI fixed -2, software set only
// - Blocked or disabled fault escalates to hardfault
// - Memory fault on protection mismatch
// - Bus fault enableable, precise or imprecise
// - Usage fault on bad instruction/state
// - Service call on its instruction
// - Debug monitor only enabled and preempting
// - Pendable service set by software only
// - Tick timer raises position fifteen
// - Peripheral lines at sixteen upward, synchronised
// - Fixed line map, reserved lines dead
// - Line taken only when enabled
//
// Chosen here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module epc_exception_ctrl
    import epc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [31:0] irqLines,
    input  wire epc_event_s  events,
    input  wire logic        firstInstr,
    input  wire logic        handlerDone,
    output epc_seq_s         seq,
    output logic      [5:0]  excNum,
    output logic             handlerMode
);
    epc_state_e        state_r;
    logic              chain_r;
    logic [5:0]        excNum_r;
    logic [NUM_POS-1:0] pend_r;
    logic [NUM_POS-1:0] active_r;
    logic              resetAct_r;
    logic [31:0]       irqMeta_r;
    logic [31:0]       irqSync_r;
    logic [31:0]       irqEn_r;
    logic [1:0]        grpSel_r;
    logic              memEn_r;
    logic              busEn_r;
    logic              useEn_r;
    logic              dbgEn_r;
    logic [2:0]        sysPri_r [NUM_SYS];
    logic [2:0]        intPri_r [NUM_IRQ];
    logic [31:0]       prdata_r;
    logic [4:0]        lvlArr   [NUM_POS];
    logic [4:0]        curGrp;
    logic [5:0]        topNum;
    logic [4:0]        bestLvl;
    logic [5:0]        bestNum;
    logic              anyPend;
    logic              reqValid;
    logic [NUM_POS-1:0] pendEff;
    logic              memOk;
    logic              busOk;
    logic              useOk;
    logic              dbgOk;
    logic              busHit;
    logic              escHard;
    logic              wrEn;
    logic              mapped;
    logic [31:0]       rdMux;

    // Group part of a rank; fixed ranks and base pass unchanged
    function automatic logic [4:0] grpOf(input logic [4:0] l, input logic [1:0] sub);
        logic [2:0] p;
        p = 3'(l - LVL_SET_BASE);
        if (l < LVL_SET_BASE || l == LVL_BASE) begin
            return l;
        end
        return LVL_SET_BASE + 5'(p & (3'h7 << sub));
    endfunction

    // Rank of every position
    always_comb begin
        for (int n = 0; n < NUM_POS; n++) begin
            lvlArr[n] = LVL_BASE;
        end
        for (int i = 0; i < NUM_IRQ; i++) begin
            lvlArr[16 + i] = LVL_SET_BASE + 5'(intPri_r[i]);
        end
        for (int i = 0; i < NUM_SYS; i++) begin
            lvlArr[SYS_POS[i]] = LVL_SET_BASE + 5'(sysPri_r[i]);
        end
        lvlArr[POS_RESET] = LVL_RESET;
        lvlArr[POS_NMI]   = LVL_NMI;
        lvlArr[POS_HARD]  = LVL_HARD;
    end

    // Current activation group and its owner
    always_comb begin
        curGrp = LVL_BASE;
        topNum = 6'h00;
        for (int n = 0; n < NUM_POS; n++) begin
            if (active_r[n] && grpOf(lvlArr[n], grpSel_r) < curGrp) begin
                curGrp = grpOf(lvlArr[n], grpSel_r);
                topNum = 6'(n);
            end
        end
        if (resetAct_r) begin
            curGrp = LVL_RESET;
        end
    end

    // Most urgent pending; strict compare keeps the lower position
    always_comb begin
        pendEff = pend_r;
        pendEff[NUM_POS-1:16] = pend_r[NUM_POS-1:16] & irqEn_r;
        bestLvl = LVL_BASE;
        bestNum = 6'h00;
        anyPend = 1'b0;
        for (int n = 0; n < NUM_POS; n++) begin
            if (pendEff[n] && (!anyPend || lvlArr[n] < bestLvl)) begin
                bestLvl = lvlArr[n];
                bestNum = 6'(n);
                anyPend = 1'b1;
            end
        end
        reqValid = anyPend && grpOf(bestLvl, grpSel_r) < curGrp;
    end

    // Fault acceptance versus escalation
    always_comb begin
        memOk   = memEn_r && grpOf(lvlArr[POS_MEM], grpSel_r) < curGrp;
        busOk   = busEn_r && grpOf(lvlArr[POS_BUS], grpSel_r) < curGrp;
        useOk   = useEn_r && grpOf(lvlArr[POS_USAGE], grpSel_r) < curGrp;
        dbgOk   = dbgEn_r && grpOf(lvlArr[POS_DEBUG], grpSel_r) < curGrp;
        busHit  = events.busPrecise || events.busImprecise;
        escHard = (events.mem && !memOk) || (busHit && !busOk)
                || (events.usage && !useOk);
    end

    // Two-stage sync; peripheral lines come from other logic
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irqMeta_r <= 32'h0000_0000;
            irqSync_r <= 32'h0000_0000;
        end else if (ce) begin
            irqMeta_r <= irqLines;
            irqSync_r <= irqMeta_r;
        end
    end

    // APB decode; one wait-free access while enabled
    assign pready  = ce;
    assign wrEn    = psel && penable && ce && pwrite && mapped;
    assign mapped  = (paddr[1:0] == 2'h0) && (paddr <= ADDR_SYS_PRI
                     || (paddr >= ADDR_INT_PRI && paddr <= ADDR_LINE_PEND));
    assign pslverr = psel && penable && !mapped;
    // Control register
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            grpSel_r <= GRP_RESET;
            memEn_r  <= 1'b0;
            busEn_r  <= 1'b0;
            useEn_r  <= 1'b0;
            dbgEn_r  <= 1'b0;
        end else if (wrEn && paddr == ADDR_CTRL) begin
            grpSel_r <= pwdata[CTRL_GRP_LSB +: 2];
            memEn_r  <= pwdata[CTRL_MEM_EN];
            busEn_r  <= pwdata[CTRL_BUS_EN];
            useEn_r  <= pwdata[CTRL_USE_EN];
            dbgEn_r  <= pwdata[CTRL_DBG_EN];
        end
    end

    // Line enables; reserved lines can never be enabled
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irqEn_r <= 32'h0000_0000;
        end else if (wrEn && paddr == ADDR_EN_SET) begin
            irqEn_r <= irqEn_r | (pwdata & IRQ_IMPL);
        end else if (wrEn && paddr == ADDR_EN_CLR) begin
            irqEn_r <= irqEn_r & ~pwdata;
        end
    end

    // Priority fields, all zero after reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < NUM_SYS; i++) begin
                sysPri_r[i] <= PRI_RESET;
            end
            for (int i = 0; i < NUM_IRQ; i++) begin
                intPri_r[i] <= PRI_RESET;
            end
        end else if (wrEn && paddr == ADDR_SYS_PRI) begin
            for (int i = 0; i < NUM_SYS; i++) begin
                sysPri_r[i] <= pwdata[SYS_FLD_W*i +: 3];
            end
        end else if (wrEn && paddr >= ADDR_INT_PRI && paddr <= ADDR_INT_LAST) begin
            for (int k = 0; k < 4; k++) begin
                intPri_r[{paddr[4:2], 2'(k)}] <= pwdata[INT_FLD_W*k +: 3];
            end
        end
    end

    // Read data captured in the setup phase
    always_comb begin
        rdMux = 32'h0000_0000;
        unique case (paddr)
            ADDR_CTRL: begin
                rdMux[CTRL_GRP_LSB +: 2] = grpSel_r;
                rdMux[CTRL_MEM_EN] = memEn_r;
                rdMux[CTRL_BUS_EN] = busEn_r;
                rdMux[CTRL_USE_EN] = useEn_r;
                rdMux[CTRL_DBG_EN] = dbgEn_r;
            end
            ADDR_EN_SET, ADDR_EN_CLR: rdMux = irqEn_r;
            ADDR_PEND: begin
                rdMux[PEND_ACT_LSB +: 6] = topNum;
                rdMux[PEND_VEC_LSB +: 6] = bestNum;
                rdMux[PEND_REQ]          = reqValid;
                rdMux[PEND_PSV_SET]      = pend_r[POS_PSV];
                rdMux[PEND_NMI_SET]      = pend_r[POS_NMI];
            end
            ADDR_SYS_PRI: begin
                for (int i = 0; i < NUM_SYS; i++) begin
                    rdMux[SYS_FLD_W*i +: 3] = sysPri_r[i];
                end
            end
            ADDR_LINE_PEND: rdMux = pend_r[NUM_POS-1:16];
            default: begin
                if (paddr >= ADDR_INT_PRI && paddr <= ADDR_INT_LAST) begin
                    for (int k = 0; k < 4; k++) begin
                        if (IRQ_IMPL[{paddr[4:2], 2'(k)}]) begin
                            rdMux[INT_FLD_W*k +: 3] = intPri_r[{paddr[4:2], 2'(k)}];
                        end
                    end
                end
            end
        endcase
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_r <= 32'h0000_0000;
        end else if (ce && psel && !penable) begin
            prdata_r <= rdMux;
        end
    end
    assign prdata = prdata_r;

    // Pending flags: clears first, so a same-cycle event wins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pend_r <= '0;
        end else if (ce) begin
            if (state_r == S_ENTRY) begin
                pend_r[excNum_r] <= 1'b0;
            end
            if (wrEn && paddr == ADDR_PEND && pwdata[PEND_PSV_CLR]) begin
                pend_r[POS_PSV] <= 1'b0;
            end
            pend_r[NUM_POS-1:16] <= pend_r[NUM_POS-1:16] & ~((state_r == S_ENTRY
                && excNum_r >= POS_IRQ0) ? 32'(1) << (excNum_r - POS_IRQ0) : 32'h0000_0000)
                | (irqSync_r & irqEn_r & IRQ_IMPL);
            if (wrEn && paddr == ADDR_PEND && pwdata[PEND_NMI_SET]) begin
                pend_r[POS_NMI] <= 1'b1;
            end
            if (escHard) begin
                pend_r[POS_HARD] <= 1'b1;
            end
            if (events.mem && memOk) begin
                pend_r[POS_MEM] <= 1'b1;
            end
            if (busHit && busOk) begin
                pend_r[POS_BUS] <= 1'b1;
            end
            if (events.usage && useOk) begin
                pend_r[POS_USAGE] <= 1'b1;
            end
            if (events.svc) begin
                pend_r[POS_SVC] <= 1'b1;
            end
            if (events.debug && dbgOk) begin
                pend_r[POS_DEBUG] <= 1'b1;
            end
            if (wrEn && paddr == ADDR_PEND && pwdata[PEND_PSV_SET]) begin
                pend_r[POS_PSV] <= 1'b1;
            end
            if (events.tick) begin
                pend_r[POS_TICK] <= 1'b1;
            end
        end
    end
    // Reset activation holds until the first instruction retires
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            resetAct_r <= 1'b1;
        end else if (ce && firstInstr) begin
            resetAct_r <= 1'b0;
        end
    end
    // Active set; nested preemption keeps several bits
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            active_r <= '0;
        end else if (ce) begin
            if (state_r == S_ENTRY) begin
                active_r[excNum_r] <= 1'b1;
            end else if (state_r == S_RUN && handlerDone && handlerMode) begin
                active_r[topNum] <= 1'b0;
            end
        end
    end
    assign handlerMode = |active_r;

    // Entry/exit sequencer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r  <= S_RUN;
            chain_r  <= 1'b0;
            excNum_r <= 6'h00;
        end else if (ce) begin
            unique case (state_r)
                S_RUN: begin
                    if (handlerDone && handlerMode) begin
                        state_r <= S_EXIT;
                    end else if (reqValid) begin
                        state_r  <= S_ENTRY;
                        chain_r  <= 1'b0;
                        excNum_r <= bestNum;
                    end
                end
                S_EXIT: begin
                    if (reqValid) begin
                        state_r  <= S_ENTRY;
                        chain_r  <= 1'b1;
                        excNum_r <= bestNum;
                    end else begin
                        state_r <= S_RUN;
                    end
                end
                S_ENTRY: state_r <= S_RUN;
            endcase
        end
    end
    assign excNum = excNum_r;
    // Core strobes; a chained entry skips the push
    always_comb begin
        seq.stackPush   = ce && state_r == S_ENTRY && !chain_r;
        seq.vectorFetch = ce && state_r == S_ENTRY;
        seq.tailChain   = ce && state_r == S_ENTRY && chain_r;
        seq.stackPop    = ce && state_r == S_EXIT && !reqValid;
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    a_preempt_entry: assert property (state_r == S_RUN && ce && reqValid && !handlerDone
        |=> state_r == S_ENTRY && excNum_r == $past(bestNum))
        else $error("preempting request not entered");
    a_push_mode: assert property (seq.stackPush |=> handlerMode)
        else $error("handler entered outside handler mode");
    a_push_fetch: assert property (seq.stackPush |-> seq.vectorFetch && !seq.stackPop)
        else $error("push without concurrent vector fetch");
    a_tail_chain: assert property (state_r == S_EXIT && ce && reqValid
        |=> !ce || (seq.tailChain && !seq.stackPush && !seq.stackPop))
        else $error("tail chain pushed or popped");
    a_exit_pop: assert property (handlerDone && ce && state_r == S_RUN && handlerMode
        |=> state_r == S_EXIT)
        else $error("handler completion not processed");
    a_reset_hold: assert property (resetAct_r |-> !seq.vectorFetch)
        else $error("entry taken during reset activation");
    a_nmi_soft: assert property ($rose(pend_r[POS_NMI])
        |-> $past(wrEn && paddr == ADDR_PEND && pwdata[PEND_NMI_SET]))
        else $error("NMI pended without software write");
    a_line_gate: assert property ((pend_r[NUM_POS-1:16] & ~$past(pend_r[NUM_POS-1:16])
        & ~$past(irqEn_r)) == 32'h0000_0000)
        else $error("disabled line became pending");
    a_reserved_quiet: assert property ((pend_r[NUM_POS-1:16] & ~IRQ_IMPL) == 32'h0)
        else $error("reserved line pending");
    a_debug_gate: assert property ($rose(pend_r[POS_DEBUG]) |-> $past(dbgEn_r))
        else $error("debug monitor pended while disabled");
    c_tail_chain: cover property (seq.tailChain);
    c_nmi_entry:  cover property (seq.stackPush && excNum == POS_NMI);
    c_hard_esc:   cover property (escHard ##[1:4] seq.vectorFetch && excNum == POS_HARD);
endmodule // epc_exception_ctrl

// ---- tb/epc_core_model.sv ----
// Core-side partner: start-up pulse and handler return timing
`timescale 1ns/1ns
module epc_core_model
    import epc_pkg::*;
#(
    parameter int START_DELAY = 20
)(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire epc_seq_s   seq,
    input  wire logic [7:0] holdLen,
    output logic            firstInstr,
    output logic            handlerDone
);
    logic [7:0] startCnt_r;
    logic [7:0] runCnt_r;
    // One start pulse per reset, late enough to let software act first
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            startCnt_r <= 8'h00;
            firstInstr <= 1'b0;
        end else begin
            firstInstr <= (startCnt_r == 8'(START_DELAY - 1));
            if (startCnt_r < 8'(START_DELAY)) startCnt_r <= startCnt_r + 8'h01;
        end
    end
    // Return after holdLen cycles; zero is a handler that never returns
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            runCnt_r <= 8'h00;
            handlerDone <= 1'b0;
        end else begin
            handlerDone <= (runCnt_r != 8'h00 && runCnt_r == holdLen);
            if (seq.stackPush || seq.tailChain) runCnt_r <= 8'h01;
            else if (runCnt_r == holdLen) runCnt_r <= 8'h00;
            else if (runCnt_r != 8'h00) runCnt_r <= runCnt_r + 8'h01;
        end
    end
endmodule // epc_core_model

// ---- tb/exception_priority_controller_tb.sv ----
// Self-checking bench for the exception priority controller
`timescale 1ns/1ns
module exception_priority_controller_tb
    import epc_pkg::*;
;
    logic        clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        ce = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] irq = 32'h0;
    epc_event_s  ev = '0;
    logic [7:0]  holdLen = 8'h00;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, err, firstInstr, handlerDone, handlerMode;
    epc_seq_s    seq;
    logic [5:0]  excNum;
    int          failures = 0;
    int          compares = 0;
    int          entries = 0;
    int          pops = 0;
    int          e0;
    // Priority read-back: three-bit fields, reserved lines stay zero
    logic [31:0] priExp [8] = '{32'h0707_0707, 32'h0707_0707, 32'h0707_0707, 32'h0707_0000,
                                32'h0707_0707, 32'h0707_0707, 32'h0000_0707, 32'h0000_0707};
    epc_exception_ctrl i_dut (.clk(clk), .reset_n(reset_n), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irqLines(irq), .events(ev),
        .firstInstr(firstInstr), .handlerDone(handlerDone), .seq(seq), .excNum(excNum),
        .handlerMode(handlerMode));
    epc_core_model #(.START_DELAY(20)) i_core (.clk(clk), .reset_n(reset_n), .seq(seq),
        .holdLen(holdLen), .firstInstr(firstInstr), .handlerDone(handlerDone));
    always #25 clk = ~clk;
    // Entry and return counts, sampled mid-cycle away from the edges
    always @(negedge clk) begin
        if (seq.stackPush === 1'b1 || seq.tailChain === 1'b1) entries++;
        if (seq.stackPop === 1'b1) pops++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer, request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse(input epc_event_s e);
        @(posedge clk);
        ev <= e;
        @(posedge clk);
        ev <= '0;
    endtask
    // Bounded wait for an entry, then check its kind and position
    task automatic expEntry(input logic [5:0] pos, input logic chained);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (seq.stackPush !== 1'b1 && seq.tailChain !== 1'b1 && n < 60);
        chk({n < 60, seq.vectorFetch, seq.tailChain, seq.stackPush, excNum},
            {1'b1, 1'b1, chained, !chained, pos});
    endtask
    task automatic quiet();
        e0 = entries;
        repeat (12) @(negedge clk);
        chk(entries, e0);
    endtask
    task automatic doReset();
        @(posedge clk);
        reset_n <= 1'b0;
        irq <= 32'h0;
        holdLen <= 8'h00;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
    endtask
    task automatic waitStart();
        do @(negedge clk); while (firstInstr !== 1'b1);
    endtask
    task automatic print_verdict();
        if (failures == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Generous bound: the whole sequence needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        print_verdict();
    end
    initial begin
        // Reset values, unmapped place, NMI held off by the reset activation
        doReset();
        // Clock enable low holds the bus answer back
        ce <= 1'b0;
        @(negedge clk);
        chk({31'h0, pready}, 32'h0);
        @(posedge clk);
        ce <= 1'b1;
        apb(1'b0, ADDR_SYS_PRI, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h0);
        apb(1'b0, ADDR_INT_LAST, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h50, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, ADDR_PEND, 32'h8000_0000);
        chk({26'h0, excNum}, 32'h0);
        expEntry(POS_NMI, 1'b0);
        apb(1'b1, ADDR_EN_SET, 32'h0000_0001);
        irq <= 32'h1;
        pulse(7'h08);
        quiet();
        // Field widths, tie order, tail chain, enable gating
        doReset();
        holdLen <= 8'h04;
        apb(1'b1, ADDR_EN_SET, 32'hFFFF_FFFF);
        apb(1'b0, ADDR_EN_SET, 32'h0);
        chk(rd, 32'h33FF_CFFF);
        apb(1'b1, ADDR_SYS_PRI, 32'hFFFF_FFFF);
        apb(1'b0, ADDR_SYS_PRI, 32'h0);
        chk(rd, 32'h0777_7777);
        for (int w = 0; w < 8; w++) begin
            apb(1'b1, ADDR_INT_PRI + 8'(4 * w), 32'hFFFF_FFFF);
            apb(1'b0, ADDR_INT_PRI + 8'(4 * w), 32'h0);
            chk(rd, priExp[w]);
        end
        pulse(7'h05);
        expEntry(POS_SVC, 1'b0);
        @(negedge clk);
        chk({31'h0, handlerMode}, 32'h1);
        e0 = pops;
        expEntry(POS_TICK, 1'b1);
        chk(pops, e0);
        repeat (10) @(negedge clk);
        chk(pops, e0 + 1);
        chk({31'h0, handlerMode}, 32'h0);
        apb(1'b1, ADDR_EN_CLR, 32'h0000_0008);
        irq <= 32'h8;
        quiet();
        apb(1'b1, ADDR_EN_SET, 32'h0000_0008);
        expEntry(POS_IRQ0 + 6'h03, 1'b0);
        // Group split: equal group waits, higher group and hard fault preempt
        doReset();
        apb(1'b1, ADDR_CTRL, 32'h0000_0001);
        apb(1'b1, ADDR_SYS_PRI, 32'h0100_2000);
        apb(1'b1, ADDR_INT_PRI, 32'h0000_0003);
        apb(1'b1, ADDR_EN_SET, 32'h0000_0001);
        irq <= 32'h1;
        expEntry(POS_IRQ0, 1'b0);
        pulse(7'h04);
        quiet();
        pulse(7'h02);
        quiet();
        pulse(7'h01);
        expEntry(POS_TICK, 1'b0);
        pulse(7'h08);
        expEntry(POS_HARD, 1'b0);
        // Enabled faults nest by level; a blocked one escalates
        doReset();
        apb(1'b1, ADDR_CTRL, 32'h0000_0B00);
        apb(1'b1, ADDR_SYS_PRI, 32'h0004_0056);
        waitStart();
        pulse(7'h40);
        expEntry(POS_MEM, 1'b0);
        pulse(7'h20);
        expEntry(POS_BUS, 1'b0);
        pulse(7'h02);
        expEntry(POS_DEBUG, 1'b0);
        pulse(7'h10);
        expEntry(POS_HARD, 1'b0);
        apb(1'b1, ADDR_PEND, 32'h1000_0000);
        apb(1'b0, ADDR_PEND, 32'h0);
        chk({31'h0, rd[28]}, 32'h1);
        apb(1'b1, ADDR_PEND, 32'h0800_0000);
        apb(1'b0, ADDR_PEND, 32'h0);
        chk({31'h0, rd[28]}, 32'h0);
        print_verdict();
    end
endmodule // exception_priority_controller_tb
